// ===== include/pp_pkg.sv
// constants for the parallel port address, pin enable and status block
// assumes a 16-bit register port with one-cycle strobes
package pp_pkg;
  localparam int             DW         = 16;
  localparam int             AW         = 4;
  // --------------------------------------------------------------------
  // register offsets (word index on the plain port)
  // --------------------------------------------------------------------
  localparam logic [AW-1:0]  OFS_ADDR   = 4'h0;
  localparam logic [AW-1:0]  OFS_PINEN  = 4'h1;
  localparam logic [AW-1:0]  OFS_STAT   = 4'h2;
  localparam logic [AW-1:0]  OFS_PAD    = 4'h3;
  localparam logic [AW-1:0]  OFS_CTRL   = 4'h4;
  localparam logic [AW-1:0]  OFS_IRQST  = 4'h5;
  localparam logic [AW-1:0]  OFS_IRQMSK = 4'h6;
  localparam logic [AW-1:0]  OFS_OUTA   = 4'h7;
  localparam logic [AW-1:0]  OFS_OUTB   = 4'h8;
  localparam logic [AW-1:0]  OFS_INA    = 4'h9;
  localparam logic [AW-1:0]  OFS_INB    = 4'hA;
  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int             B_SEL2     = 15;
  localparam int             B_SEL1     = 14;
  localparam int             B_ALLFULL  = 15;
  localparam int             B_OVF      = 14;
  localparam int             B_INSLOT   = 8;
  localparam int             B_ALLEMPTY = 7;
  localparam int             B_UNF      = 6;
  localparam int             B_OUTSLOT  = 0;
  localparam int             B_TTL      = 0;
  localparam int             B_MODE     = 0;
  localparam int             B_CSF      = 2;
  localparam int             B_STEP     = 4;
  localparam int             B_MUX      = 6;
  // irq status bits
  localparam int             E_OVF      = 0;
  localparam int             E_UNF      = 1;
  localparam int             E_HWR      = 2;
  localparam int             E_HRD      = 3;
  localparam int             NEV        = 4;
  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [DW-1:0]  RST_WORD   = 16'h0000;
  localparam logic [3:0]     RST_INFULL = 4'h0;
  localparam logic [3:0]     RST_OUTEMP = 4'hF;
  localparam logic [1:0]     RST_PTR    = 2'h0;
  // --------------------------------------------------------------------
  // modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00, MODE_ADDRSLV = 2'b01,
    MODE_MASTER2 = 2'b10, MODE_MASTER1 = 2'b11
  } port_mode_t;
  typedef enum logic [1:0] {
    CSF_ADDR = 2'b00, CSF_TWO_ONLY = 2'b01, CSF_BOTH = 2'b10,
    CSF_RSVD = 2'b11
  } select_function_t;
  typedef enum logic [1:0] {
    STEP_HOLD = 2'b00, STEP_INC = 2'b01, STEP_DEC = 2'b10,
    STEP_AUTO = 2'b11
  } address_step_t;
  typedef enum logic [1:0] {
    MUX_NONE = 2'b00, MUX_LOW8 = 2'b01, MUX_ALL16 = 2'b10,
    MUX_RSVD = 2'b11
  } address_mux_t;
endpackage : pp_pkg

// ===== rtl/parallel_port_addr_status.sv
// parallel port address/chip-select, pin enables, slave buffer status
// assumes host strobes and chip select are active high and asynchronous
//
// Functional notes
// R1: select-two flag drives chip select two, else A15
// R2: select-one flag drives chip select one, else A14
// R3: fourteen-bit address drives address lines in master
// R4: top two pin enables give pins to port
// R5: middle pin enables make address lines
// R6: low two pin enables make address/latch pins
// R7: all-full reads one only when every buffer full
// R8: host write to full buffer sets overflow
// R9: slot full set on host write, cleared by read
// R10: all-empty reads one only when every buffer empty
// R11: host read of empty buffer sets underflow
// R12: slot empty cleared when software writes buffer
// R13: two address bits pick byte buffer zero..three
// R14: pad bit picks TTL or Schmitt inputs
// R15: mode field picks legacy, addressable or master
// R16: select function field maps top pins
// R17: step field increments, decrements, autoincrements or holds
// R18: mux field puts address onto data pins; here it only clears address lines 7:0 or 15:0 and drives o_address_mux_field
// R19: host holds address and select through strobe
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module parallel_port_addr_status
  import pp_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic [pp_pkg::AW-1:0] i_reg_addr,
  input  wire logic [pp_pkg::DW-1:0] i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic [pp_pkg::DW-1:0]  o_reg_rdata,
  input  wire logic              i_host_cs,
  input  wire logic              i_host_rd,
  input  wire logic              i_host_wr,
  input  wire logic [1:0]        i_host_addr,
  input  wire logic [7:0]        i_port_data_in,
  output logic [7:0]             o_port_data_out,
  output logic                   o_port_data_oe,
  output logic [15:0]            o_port_address_lines,
  output logic [15:0]            o_pin_function_enable,
  output logic                   o_chip_select_one,
  output logic                   o_chip_select_two,
  output logic [1:0]             o_address_mux_field,
  output logic [1:0]             o_port_mode_field,
  output logic                   o_ttl_input_select,
  output logic                   o_irq
);
  // ----------------------------------------------------------------------
  // host pin synchronisers
  // ----------------------------------------------------------------------
  logic [11:0] sync1_ff, sync2_ff;
  logic [1:0]  strb_prev_ff;
  logic [11:0] pins_raw;
  assign pins_raw = {i_host_cs, i_host_rd, i_host_wr, i_host_addr,
                     i_port_data_in[6:0]};
  // data bit 7 rides a separate pair to keep widths exact
  logic        d7_s1_ff, d7_s2_ff;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_ff     <= 12'h000;
      sync2_ff     <= 12'h000;
      d7_s1_ff     <= 1'b0;
      d7_s2_ff     <= 1'b0;
      strb_prev_ff <= 2'h0;
    end else begin
      sync1_ff     <= pins_raw;
      sync2_ff     <= sync1_ff;
      d7_s1_ff     <= i_port_data_in[7];
      d7_s2_ff     <= d7_s1_ff;
      strb_prev_ff <= sync2_ff[10:9];
    end
  end

  logic       h_cs, h_rd, h_wr;
  logic [1:0] h_addr;
  logic [7:0] h_data;
  logic       host_rd_ev, host_wr_ev;
  assign h_cs   = sync2_ff[11];
  assign h_rd   = sync2_ff[10];
  assign h_wr   = sync2_ff[9];
  assign h_addr = sync2_ff[8:7];
  assign h_data = {d7_s2_ff, sync2_ff[6:0]};

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [DW-1:0] paddr_ff, nxt_paddr;
  logic [DW-1:0] pinen_ff, nxt_pinen;
  logic          pad_ff, nxt_pad;
  logic [7:0]    ctrl_ff, nxt_ctrl;
  logic [3:0]    in_full_ff, nxt_in_full;
  logic [3:0]    out_empty_ff, nxt_out_empty;
  logic          ovf_ff, nxt_ovf;
  logic          unf_ff, nxt_unf;
  logic [NEV-1:0] irq_st_ff, nxt_irq_st;
  logic [NEV-1:0] irq_msk_ff, nxt_irq_msk;
  logic [7:0]    in_buf_ff  [4];
  logic [7:0]    out_buf_ff [4];
  logic [7:0]    nxt_in_buf [4];
  logic [7:0]    nxt_out_buf[4];
  logic [1:0]    in_ptr_ff, nxt_in_ptr, out_ptr_ff, nxt_out_ptr;

  port_mode_t       mode;
  select_function_t csf;
  address_step_t    step;
  address_mux_t     amux;
  assign mode = port_mode_t'(ctrl_ff[B_MODE+:2]);                    // [R15]
  assign csf  = select_function_t'(ctrl_ff[B_CSF+:2]);
  assign step = address_step_t'(ctrl_ff[B_STEP+:2]);
  assign amux = address_mux_t'(ctrl_ff[B_MUX+:2]);

  logic is_slave, is_master;
  assign is_slave  = (mode == MODE_LEGACY) || (mode == MODE_ADDRSLV);
  assign is_master = !is_slave;

  // strobe edges count only while selected and in a slave mode
  assign host_rd_ev = is_slave && h_cs && h_rd && !strb_prev_ff[1];
  assign host_wr_ev = is_slave && h_cs && h_wr && !strb_prev_ff[0];

  // buffer select: address bits in addressable mode, pointer in legacy
  function automatic logic [1:0] buf_sel(input port_mode_t m,
                                          input logic [1:0] a,
                                          input logic [1:0] p);
    buf_sel = (m == MODE_ADDRSLV) ? a : p;                          // [R13]
  endfunction : buf_sel

  logic [1:0] wsel, rsel;
  logic       sw_wr_a, sw_wr_b, sw_rd_a, sw_rd_b, auto_inc;
  assign wsel     = buf_sel(mode, h_addr, in_ptr_ff);               // [R19]
  assign rsel     = buf_sel(mode, h_addr, out_ptr_ff);
  assign sw_wr_a  = i_reg_wr && (i_reg_addr == OFS_OUTA);
  assign sw_wr_b  = i_reg_wr && (i_reg_addr == OFS_OUTB);
  assign sw_rd_a  = i_reg_rd && (i_reg_addr == OFS_INA);
  assign sw_rd_b  = i_reg_rd && (i_reg_addr == OFS_INB);
  assign auto_inc = (mode == MODE_LEGACY) && (step == STEP_AUTO);   // [R17]

  logic ev_ovf, ev_unf;
  assign ev_ovf = host_wr_ev && in_full_ff[wsel];
  assign ev_unf = host_rd_ev && out_empty_ff[rsel];

  always_comb begin
    nxt_paddr     = paddr_ff;
    nxt_pinen     = pinen_ff;
    nxt_pad       = pad_ff;
    nxt_ctrl      = ctrl_ff;
    nxt_in_full   = in_full_ff;
    nxt_out_empty = out_empty_ff;
    nxt_ovf       = ovf_ff;
    nxt_unf       = unf_ff;
    nxt_irq_st    = irq_st_ff;
    nxt_irq_msk   = irq_msk_ff;
    nxt_in_buf    = in_buf_ff;
    nxt_out_buf   = out_buf_ff;
    nxt_in_ptr    = in_ptr_ff;
    nxt_out_ptr   = out_ptr_ff;
    // software writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        OFS_ADDR:   nxt_paddr   = i_reg_wdata;                      // [R3]
        OFS_PINEN:  nxt_pinen   = i_reg_wdata;
        OFS_PAD:    nxt_pad     = i_reg_wdata[B_TTL];
        OFS_CTRL:   nxt_ctrl    = i_reg_wdata[7:0];
        OFS_STAT: begin
          nxt_ovf = ovf_ff & i_reg_wdata[B_OVF];
          nxt_unf = unf_ff & i_reg_wdata[B_UNF];
        end
        OFS_IRQST:  nxt_irq_st  = irq_st_ff & ~i_reg_wdata[NEV-1:0];
        OFS_IRQMSK: nxt_irq_msk = i_reg_wdata[NEV-1:0];
        default: ;
      endcase
    end
    if (sw_wr_a) begin
      nxt_out_buf[0]   = i_reg_wdata[7:0];
      nxt_out_buf[1]   = i_reg_wdata[15:8];
      nxt_out_empty[1:0] = 2'b00;                                   // [R12]
    end
    if (sw_wr_b) begin
      nxt_out_buf[2]   = i_reg_wdata[7:0];
      nxt_out_buf[3]   = i_reg_wdata[15:8];
      nxt_out_empty[3:2] = 2'b00;                                   // [R12]
    end
    if (sw_rd_a) nxt_in_full[1:0] = 2'b00;                          // [R9]
    if (sw_rd_b) nxt_in_full[3:2] = 2'b00;                          // [R9]
    // master cycle: an OUTA write or INA read steps the address
    if (is_master && (sw_wr_a || sw_rd_a)) begin
      case (step)                                                   // [R17]
        STEP_INC: nxt_paddr[13:0] = paddr_ff[13:0] + 14'h0001;
        STEP_DEC: nxt_paddr[13:0] = paddr_ff[13:0] - 14'h0001;
        default:  nxt_paddr[13:0] = paddr_ff[13:0];
      endcase
    end
    // host side events win over software clears in the same cycle
    if (host_wr_ev) begin
      if (in_full_ff[wsel]) begin
        nxt_ovf = 1'b1;                                             // [R8]
      end else begin
        nxt_in_buf[wsel]  = h_data;
        nxt_in_full[wsel] = 1'b1;                                   // [R9]
      end
      if (auto_inc) nxt_in_ptr = in_ptr_ff + 2'h1;
    end
    if (host_rd_ev) begin
      if (out_empty_ff[rsel]) nxt_unf = 1'b1;                       // [R11]
      else nxt_out_empty[rsel] = 1'b1;
      if (auto_inc) nxt_out_ptr = out_ptr_ff + 2'h1;
    end
    if (ev_ovf)     nxt_irq_st[E_OVF] = 1'b1;
    if (ev_unf)     nxt_irq_st[E_UNF] = 1'b1;
    if (host_wr_ev) nxt_irq_st[E_HWR] = 1'b1;
    if (host_rd_ev) nxt_irq_st[E_HRD] = 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      paddr_ff     <= RST_WORD;
      pinen_ff     <= RST_WORD;
      pad_ff       <= 1'b0;
      ctrl_ff      <= 8'h00;
      in_full_ff   <= RST_INFULL;
      out_empty_ff <= RST_OUTEMP;
      ovf_ff       <= 1'b0;
      unf_ff       <= 1'b0;
      irq_st_ff    <= '0;
      irq_msk_ff   <= '0;
      in_ptr_ff    <= RST_PTR;
      out_ptr_ff   <= RST_PTR;
      for (int i = 0; i < 4; i++) begin
        in_buf_ff[i]  <= 8'h00;
        out_buf_ff[i] <= 8'h00;
      end
    end else begin
      paddr_ff     <= nxt_paddr;
      pinen_ff     <= nxt_pinen;
      pad_ff       <= nxt_pad;
      ctrl_ff      <= nxt_ctrl;
      in_full_ff   <= nxt_in_full;
      out_empty_ff <= nxt_out_empty;
      ovf_ff       <= nxt_ovf;
      unf_ff       <= nxt_unf;
      irq_st_ff    <= nxt_irq_st;
      irq_msk_ff   <= nxt_irq_msk;
      in_ptr_ff    <= nxt_in_ptr;
      out_ptr_ff   <= nxt_out_ptr;
      in_buf_ff    <= nxt_in_buf;
      out_buf_ff   <= nxt_out_buf;
    end
  end

  // ----------------------------------------------------------------------
  // read mux and pin outputs
  // ----------------------------------------------------------------------
  logic [DW-1:0] stat_word, nxt_rdata;
  assign stat_word = {&in_full_ff, ovf_ff, 2'b00, in_full_ff,       // [R7]
                      &out_empty_ff, unf_ff, 2'b00, out_empty_ff};  // [R10]

  logic [15:0] nxt_alines;
  logic        nxt_cs1, nxt_cs2, nxt_oe, nxt_irq;
  logic [7:0]  nxt_dout;

  always_comb begin
    nxt_rdata = RST_WORD;
    if (i_reg_rd) begin
      case (i_reg_addr)
        OFS_ADDR:   nxt_rdata = paddr_ff;
        OFS_PINEN:  nxt_rdata = pinen_ff;
        OFS_STAT:   nxt_rdata = stat_word;
        OFS_PAD:    nxt_rdata = {15'h0000, pad_ff};
        OFS_CTRL:   nxt_rdata = {8'h00, ctrl_ff};
        OFS_IRQST:  nxt_rdata = {12'h000, irq_st_ff};
        OFS_IRQMSK: nxt_rdata = {12'h000, irq_msk_ff};
        OFS_INA:    nxt_rdata = {in_buf_ff[1], in_buf_ff[0]};
        OFS_INB:    nxt_rdata = {in_buf_ff[3], in_buf_ff[2]};
        default:    nxt_rdata = RST_WORD;
      endcase
    end
    // top pins: chip selects or address bits 15/14
    nxt_cs2 = (csf == CSF_BOTH || csf == CSF_TWO_ONLY)
              && paddr_ff[B_SEL2];                  // [R1] [R16]
    nxt_cs1 = (csf == CSF_BOTH) && paddr_ff[B_SEL1];  // [R2] [R16]
    nxt_alines = paddr_ff;                                          // [R3]
    if (csf == CSF_BOTH) nxt_alines[15:14] = 2'b00;
    if (csf == CSF_TWO_ONLY) nxt_alines[15] = 1'b0;
    case (amux)                                                     // [R18]
      MUX_LOW8:  nxt_alines[7:0] = 8'h00;
      MUX_ALL16: nxt_alines      = 16'h0000;
      default: ;
    endcase
    // pins not enabled stay general I/O and carry nothing from here
    nxt_alines = nxt_alines & pinen_ff;       // [R4] [R5] [R6]
    if (!pinen_ff[15]) nxt_cs2 = 1'b0;                              // [R4]
    if (!pinen_ff[14]) nxt_cs1 = 1'b0;                              // [R4]
    if (!is_master) begin
      nxt_alines = 16'h0000;
      nxt_cs1    = 1'b0;
      nxt_cs2    = 1'b0;
    end
    // slave read data held while host read strobe and select stand
    nxt_oe   = is_slave && h_cs && h_rd;
    nxt_dout = o_port_data_out;
    if (host_rd_ev) nxt_dout = out_buf_ff[rsel];                    // [R13]
    nxt_irq  = |(nxt_irq_st & nxt_irq_msk);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata           <= RST_WORD;
      o_port_data_out       <= 8'h00;
      o_port_data_oe        <= 1'b0;
      o_port_address_lines  <= RST_WORD;
      o_pin_function_enable <= RST_WORD;
      o_chip_select_one     <= 1'b0;
      o_chip_select_two     <= 1'b0;
      o_address_mux_field   <= 2'b00;
      o_port_mode_field     <= 2'b00;
      o_ttl_input_select    <= 1'b0;
      o_irq                 <= 1'b0;
    end else begin
      o_reg_rdata           <= nxt_rdata;
      o_port_data_out       <= nxt_dout;
      o_port_data_oe        <= nxt_oe;
      o_port_address_lines  <= nxt_alines;
      o_pin_function_enable <= pinen_ff;      // [R4] [R5] [R6]
      o_chip_select_one     <= nxt_cs1;
      o_chip_select_two     <= nxt_cs2;
      o_address_mux_field   <= ctrl_ff[B_MUX+:2];
      o_port_mode_field     <= ctrl_ff[B_MODE+:2];                  // [R15]
      o_ttl_input_select    <= pad_ff;                              // [R14]
      o_irq                 <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_stat_read;
    i_reg_rd && (i_reg_addr == OFS_STAT);
  endsequence
  property p_all_full;
    s_stat_read |=> o_reg_rdata[B_ALLFULL] == &$past(in_full_ff);
  endproperty
  a_all_full: assert property (p_all_full) // [R7]
    else $error("all-full status wrong");
  property p_all_empty;
    s_stat_read |=> o_reg_rdata[B_ALLEMPTY] == &$past(out_empty_ff);
  endproperty
  a_all_empty: assert property (p_all_empty) // [R10]
    else $error("all-empty status wrong");
  property p_ovf;
    ev_ovf |=> ovf_ff ##1 (ovf_ff || $past(i_reg_wr));
  endproperty
  a_ovf: assert property (p_ovf) // [R8]
    else $error("overflow not set");
  property p_unf;
    ev_unf |=> unf_ff;
  endproperty
  a_unf: assert property (p_unf) // [R11]
    else $error("underflow not set");
  property p_in_clear;
    (sw_rd_a && !host_wr_ev) |=> in_full_ff[1:0] == 2'b00;
  endproperty
  a_in_clear: assert property (p_in_clear) // [R9]
    else $error("input slot not cleared by read");
  property p_out_fill;
    (sw_wr_b && !host_rd_ev) |=> out_empty_ff[3:2] == 2'b00;
  endproperty
  a_out_fill: assert property (p_out_fill) // [R12]
    else $error("output slot empty after write");
  property p_cs2;
    (is_master && csf == CSF_BOTH && paddr_ff[B_SEL2] && pinen_ff[15])
      |=> o_chip_select_two && !o_port_address_lines[15];
  endproperty
  a_cs2: assert property (p_cs2) // [R1]
    else $error("chip select two not driven");
  property p_cs1_addr;
    (is_master && csf == CSF_ADDR && amux != MUX_ALL16 && pinen_ff[14])
      |=> !o_chip_select_one
          && o_port_address_lines[14] == $past(paddr_ff[B_SEL1]);
  endproperty
  a_cs1_addr: assert property (p_cs1_addr) // [R2]
    else $error("pin fourteen not carrying address");
  property p_ttl;
    ##1 o_ttl_input_select == $past(pad_ff);
  endproperty
  a_ttl: assert property (p_ttl) // [R14]
    else $error("input buffer select mismatch");
  property p_slot_pick;
    (host_wr_ev && mode == MODE_ADDRSLV && !in_full_ff[h_addr])
      |=> in_full_ff[$past(h_addr)]
          && in_buf_ff[$past(h_addr)] == $past(h_data);
  endproperty
  a_slot_pick: assert property (p_slot_pick) // [R13]
    else $error("wrong input buffer chosen");
endmodule : parallel_port_addr_status

// ===== testbench/host_model.sv
// external host that drives the slave port strobes and data
// assumes the port samples its pins on the rising clock edge
`timescale 1ns/1ps
module host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_port_data,
  input  wire logic       i_port_oe,
  output logic            o_cs,
  output logic            o_rd,
  output logic            o_wr,
  output logic [1:0]      o_addr,
  output logic [7:0]      o_data
);
  initial begin
    o_cs = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 2'h0;
    o_data = 8'h5A;
  end
  // select and address settle a cycle before the strobe, held past it
  task automatic host_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_cs <= 1'b1;
    o_addr <= a;
    o_data <= d;
    @(posedge i_sys_clk);
    o_wr <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_wr <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    o_cs <= 1'b0;
    o_data <= ~d; // released line must not look like the old byte
  endtask : host_write
  // strobe held six cycles: two sync stages plus answer latency
  task automatic host_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_cs <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_rd <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    d = i_port_oe ? i_port_data : 8'hFF; // undriven bus floats high
    o_rd <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    o_cs <= 1'b0;
  endtask : host_read
endmodule : host_model

// ===== testbench/parallel_port_addr_status_tb_top.sv
// register and host-port test of the address and status block
// assumes pp_pkg and host_model are compiled first
`timescale 1ns/1ps
module parallel_port_addr_status_tb_top;
  import pp_pkg::*;
  logic          i_sys_clk, i_rst_n, reg_wr, reg_rd;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, rdata, e;
  logic          cs, hrd, hwr, oe, cs1, cs2, ttl, irq;
  logic [1:0]    haddr, mux, mode;
  logic [7:0]    hdata, dout, b;
  logic [15:0]   alines, pinen;
  int            n_mismatch, n_compared, cyc;

  parallel_port_addr_status i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_host_cs(cs), .i_host_rd(hrd),
    .i_host_wr(hwr), .i_host_addr(haddr), .i_port_data_in(hdata),
    .o_port_data_out(dout), .o_port_data_oe(oe), .o_port_address_lines(alines),
    .o_pin_function_enable(pinen), .o_chip_select_one(cs1),
    .o_chip_select_two(cs2), .o_address_mux_field(mux),
    .o_port_mode_field(mode), .o_ttl_input_select(ttl), .o_irq(irq));
  host_model i_host (.i_sys_clk(i_sys_clk), .i_port_data(dout), .o_cs(cs),
    .o_rd(hrd), .o_wr(hwr), .o_addr(haddr), .o_data(hdata), .i_port_oe(oe));

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // hang guard: the whole run needs about two hundred and fifty cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] x);
    n_compared++;
    if (g !== x) begin
      $display("BAD %0t got %h want %h", $time, g, x);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] x,
                    input logic [DW-1:0] m = 16'hFFFF);
    @(posedge i_sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata & m, x);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask : settle
  task automatic do_reset;
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
  endtask : do_reset
  task automatic wrap_up;
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    {i_rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    cyc = 0;
    do_reset();
    rd(OFS_STAT, 16'h008F);
    rd(OFS_ADDR, 16'h0000);
    rd(OFS_PINEN, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(OFS_PAD, 16'hFFFF);
    rd(OFS_PAD, 16'h0001);
    settle();
    chk(16'(ttl), 16'h0001);
    wr(OFS_PAD, 16'h0000);
    settle();
    chk(16'(ttl), 16'h0000);
    wr(OFS_CTRL, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      i_host.host_write(2'(i), 8'hA0 + 8'(i));
    end
    rd(OFS_STAT, 16'h078F);
    i_host.host_write(2'h3, 8'hA3);
    rd(OFS_STAT, 16'h8F8F);
    i_host.host_write(2'h0, 8'h55);
    rd(OFS_STAT, 16'hCF8F);
    rd(OFS_INA, 16'hA1A0);
    rd(OFS_STAT, 16'h4C8F);
    wr(OFS_STAT, 16'h0000);
    rd(OFS_INB, 16'hA3A2);
    rd(OFS_STAT, 16'h008F);
    wr(OFS_OUTA, 16'h2211);
    rd(OFS_STAT, 16'h000C);
    i_host.host_read(2'h1, b);
    chk(16'(b), 16'h0022);
    chk(16'(oe), 16'h0000);
    i_host.host_read(2'h2, b);
    chk(16'(b), 16'h0000);
    rd(OFS_STAT, 16'h0040, 16'h0040);
    chk(16'(irq), 16'h0000);
    rd(OFS_IRQST, 16'h000F);
    wr(OFS_IRQMSK, 16'h0002);
    settle();
    chk(16'(irq), 16'h0001);
    wr(OFS_IRQST, 16'h0002);
    settle();
    chk(16'(irq), 16'h0000);
    rd(OFS_IRQST, 16'h000D);
    do_reset();
    wr(OFS_CTRL, 16'h0030);
    i_host.host_write(2'h3, 8'h01);
    i_host.host_write(2'h3, 8'h02);
    rd(OFS_STAT, 16'h038F);
    do_reset();
    wr(OFS_PINEN, 16'hFFFF);
    wr(OFS_ADDR, 16'hC123);
    wr(OFS_CTRL, 16'h000A);
    settle();
    chk(16'({cs2, cs1}), 16'h0003);
    chk(alines & 16'h3FFF, 16'h0123);
    wr(OFS_ADDR, 16'h4123);
    settle();
    chk(16'({cs2, cs1}), 16'h0001);
    wr(OFS_CTRL, 16'h0006);
    wr(OFS_ADDR, 16'hC123);
    settle();
    chk(16'({cs2, cs1}), 16'h0002);
    wr(OFS_CTRL, 16'h0002);
    settle();
    chk(16'({cs2, cs1}), 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CTRL, 16'h0002 | 16'(m << 6));
      settle();
      chk(16'(mux), 16'(m));
      e = (m == 0) ? 16'h0123 : (m == 1) ? 16'h0100 : 16'h0000;
      chk(alines & 16'h3FFF, e);
    end
    wr(OFS_PINEN, 16'hC0FF);
    wr(OFS_CTRL, 16'h0002);
    settle();
    chk(pinen, 16'hC0FF);
    chk(alines & 16'h3FFF, 16'h0023);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_ADDR, 16'h0123);
      wr(OFS_CTRL, 16'h0002 | 16'(s << 4));
      wr(OFS_OUTA, 16'h0000);
      e = (s == 1) ? 16'h0124 : (s == 2) ? 16'h0122 : 16'h0123;
      rd(OFS_ADDR, e);
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CTRL, 16'(m));
      settle();
      chk(16'(mode), 16'(m));
    end
    wrap_up();
  end
endmodule : parallel_port_addr_status_tb_top
